// File: hdl/cdr_pkg.sv
/*
 * Constants, register map and carrier types for the console deposit,
 * examine and read-in block.
 * Assumes an 18-bit machine word and an 8K word address space.
 */
package cdr_pkg;
    localparam int WORD_W  = 18;
    localparam int ADDR_W  = 13;
    localparam int FRAME_W = 8;
    localparam int SEG_W   = 6;
    localparam int SEG_CNT = 3;
    localparam int CNT_W   = 2;
    localparam int IRQ_W   = 4;
    localparam int KEY_W   = 7;

    // Octal 10000 is this bit of the address
    localparam int HI_ADDR_BIT   = 12;
    localparam int BIN_FRAME_BIT = 7;
    localparam logic [1:0] PUNCH_BIN_TAG = 2'h2;

    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_RD_BUF   = 8'h08;
    localparam logic [7:0] OFF_PUN_BUF  = 8'h0c;
    localparam logic [7:0] OFF_SWITCH   = 8'h10;
    localparam logic [7:0] OFF_PC       = 8'h14;
    localparam logic [7:0] OFF_AC       = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

    localparam int CTRL_RD_BIN  = 0;
    localparam int CTRL_PUN_BIN = 1;
    localparam int CTRL_RD_GO   = 2;

    localparam int IRQ_RD_DONE  = 0;
    localparam int IRQ_CON_DONE = 1;
    localparam int IRQ_RI_END   = 2;
    localparam int IRQ_PUNCH    = 3;

    localparam int KEY_DEP    = 0;
    localparam int KEY_DEPN   = 1;
    localparam int KEY_EXAM   = 2;
    localparam int KEY_EXAMN  = 3;
    localparam int KEY_START  = 4;
    localparam int KEY_CONT   = 5;
    localparam int KEY_READIN = 6;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } cdr_mem_req_t;

    typedef struct packed {
        logic [KEY_W-1:0]  key;
        logic              ready;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] acc;
    } cdr_console_t;

    localparam int CON_W = KEY_W + 1 + ADDR_W + WORD_W;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_WR      = 5'h02,
        ST_RD      = 5'h04,
        ST_RI_WAIT = 5'h08,
        ST_RI_WR   = 5'h10
    } cdr_state_t;
endpackage : cdr_pkg

// File: hdl/cdr_sync.sv
/*
 * Two-stage synchroniser for a vector of console pins.
 * Assumes each bit is an independent slow level; no bus coherence.
 */
`timescale 1ns/1ps
`default_nettype none
module cdr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("cdr_sync needs WIDTH of at least one");
        end
    endgenerate

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : cdr_sync
`default_nettype wire

// File: hdl/cdr_console.sv
/*
 * Operator console control: deposit, examine, start, continue, read-in,
 * paper-tape reader flags and assembly buffer, binary punch frame, APB.
 * Assumes memory and reader control run on sys_clk_i; switches are pins.
 */
// Summary of operation
// - Deposit writes switch word at switch address; AC, MB, MA, PC=MA+1 updated.
// - Deposit-next stores switch word at PC, then PC increments by one.
// - Examine reads switch address; view_sequential_key reads following cell without switches.
// - Binary reader buffer is three six-bit shift stages forming one word.
// - Binary punching uses only the six low punch buffer bits.
// - Reader run flop is set while tape moves, cleared when reading stops.
// - Reader mode flop selects binary assembly of frames.
// - Done flag sets when buffer holds a complete item for the processor.
// - Read-in key loads binary tape from switch address without stored program.
// - In 4K configuration the octal 10000 address bit is ignored.
// - Start key loads PC from address switches and starts execution.
// - Program can read accumulator switches as an input word.
`timescale 1ns/1ps
`default_nettype none
module cdr_console
    import cdr_pkg::*;
#(
    parameter bit MEM_4K = 1'b0
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq_o,
    input  wire logic [KEY_W-1:0]      key_pins_i,
    input  wire logic [ADDR_W-1:0]     addr_switch_i,
    input  wire logic [WORD_W-1:0]     acc_switch_i,
    input  wire logic                  reader_ready_i,
    output cdr_pkg::cdr_mem_req_t      mem_req_o,
    output logic                       mem_valid_o,
    input  wire logic                  mem_ack_i,
    input  wire logic [WORD_W-1:0]     mem_rdata_i,
    input  wire logic                  frame_valid_i,
    input  wire logic [FRAME_W-1:0]    frame_i,
    input  wire logic                  tape_end_i,
    output logic                       reader_run_o,
    output logic                       reader_binary_o,
    output logic                       reader_done_o,
    output logic      [WORD_W-1:0]     reader_assembly_buffer_o,
    output logic      [FRAME_W-1:0]    punch_frame_o,
    output logic                       punch_strobe_o,
    output logic                       cpu_run_o,
    output logic      [ADDR_W-1:0]     program_counter_o,
    output logic      [WORD_W-1:0]     accumulator_reg_o,
    output logic      [WORD_W-1:0]     memory_buffer_reg_o,
    output logic      [ADDR_W-1:0]     memory_address_reg_o
);
    import cdr_pkg::*;

    generate
        if (SEG_W * SEG_CNT != WORD_W) begin : g_bad_seg
            $error("three six-bit stages must fill one word");
        end
    endgenerate

    // Synchronised console pins
    cdr_console_t con_s;
    logic [CON_W-1:0] con_raw;
    assign con_raw = {key_pins_i, reader_ready_i, addr_switch_i, acc_switch_i};

    cdr_sync #(.WIDTH(CON_W)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (con_raw),
        .sync_o    (con_s)
    );

    logic [KEY_W-1:0] key_q_r;
    wire  [KEY_W-1:0] key_rise = con_s.key & ~key_q_r;

    // Address fold for the small memory
    localparam logic [ADDR_W-1:0] ADDR_MASK =
        MEM_4K ? ~(ADDR_W'(1) << HI_ADDR_BIT) : '1;
    function automatic logic [ADDR_W-1:0] fold(input logic [ADDR_W-1:0] a);
        fold = a & ADDR_MASK;
    endfunction : fold

    // State
    cdr_state_t                state_r, state_nxt;
    cdr_mem_req_t              mem_req_r;
    logic                      mem_valid_r;
    logic [ADDR_W-1:0]         pc_r, ma_r, ri_addr_r;
    logic [WORD_W-1:0]         ac_r, mb_r;
    logic                      cpu_run_r;
    logic                      rd_run_r, rd_mode_r, rd_done_r;
    logic [WORD_W-1:0]         rd_buf_r;
    logic [CNT_W-1:0]          seg_cnt_r;
    logic [WORD_W-1:0]         pun_buf_r;
    logic                      pun_mode_r;
    logic [FRAME_W-1:0]        pun_frame_r;
    logic                      pun_stb_r;
    logic [IRQ_W-1:0]          irq_stat_r, irq_mask_r, irq_stat_nxt;
    logic                      irq_r;
    logic [31:0]               prdata_r;
    logic                      pready_r, pslverr_r;

    // APB decode
    wire apb_setup = psel & ~penable;
    wire apb_done  = psel & penable & pready_r;
    wire apb_wr    = apb_done & pwrite;
    wire apb_rd    = apb_done & ~pwrite;
    wire hit_ctrl  = paddr == OFF_CTRL;
    wire hit_stat  = paddr == OFF_STATUS;
    wire hit_rbuf  = paddr == OFF_RD_BUF;
    wire hit_pbuf  = paddr == OFF_PUN_BUF;
    wire hit_sw    = paddr == OFF_SWITCH;
    wire hit_pc    = paddr == OFF_PC;
    wire hit_ac    = paddr == OFF_AC;
    wire hit_istat = paddr == OFF_IRQ_STAT;
    wire hit_imask = paddr == OFF_IRQ_MASK;
    wire hit_any   = hit_ctrl | hit_stat | hit_rbuf | hit_pbuf | hit_sw |
                     hit_pc | hit_ac | hit_istat | hit_imask;
    wire wr_ctrl   = apb_wr & hit_ctrl;
    wire wr_pbuf   = apb_wr & hit_pbuf;
    wire rd_rbuf   = apb_rd & hit_rbuf;

    wire [31:0] rdata_mux =
        hit_ctrl  ? 32'({pun_mode_r, rd_mode_r}) :
        hit_stat  ? 32'({state_r, cpu_run_r, rd_done_r, rd_mode_r, rd_run_r}) :
        hit_rbuf  ? 32'(rd_buf_r) :
        hit_pbuf  ? 32'(pun_buf_r) :
        hit_sw    ? 32'(con_s.acc) :
        hit_pc    ? 32'(pc_r) :
        hit_ac    ? 32'(ac_r) :
        hit_istat ? 32'(irq_stat_r) :
        hit_imask ? 32'(irq_mask_r) : 32'h0;

    // Console and read-in sequencing
    wire idle     = state_r == ST_IDLE;
    wire con_ok   = idle & ~cpu_run_r;
    wire do_dep   = con_ok & key_rise[KEY_DEP];
    wire do_depn  = con_ok & ~key_rise[KEY_DEP] & key_rise[KEY_DEPN];
    wire do_exam  = con_ok & ~(|key_rise[KEY_DEPN:KEY_DEP]) & key_rise[KEY_EXAM];
    wire do_examn = con_ok & ~(|key_rise[KEY_EXAM:KEY_DEP]) & key_rise[KEY_EXAMN];
    wire do_ri    = con_ok & ~(|key_rise[KEY_EXAMN:KEY_DEP]) & key_rise[KEY_READIN];
    wire do_start = con_ok & key_rise[KEY_START];
    wire do_cont  = con_ok & key_rise[KEY_CONT];
    wire mem_fin  = mem_valid_r & mem_ack_i;
    wire ri_word  = (state_r == ST_RI_WAIT) & rd_done_r;
    wire ri_end   = (state_r == ST_RI_WAIT) & ~rd_done_r & tape_end_i;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (do_dep | do_depn)
                    state_nxt = ST_WR;
                else if (do_exam | do_examn)
                    state_nxt = ST_RD;
                else if (do_ri)
                    state_nxt = ST_RI_WAIT;
            end
            ST_WR, ST_RD: begin
                if (mem_fin)
                    state_nxt = ST_IDLE;
            end
            ST_RI_WAIT: begin
                if (ri_word)
                    state_nxt = ST_RI_WR;
                else if (ri_end)
                    state_nxt = ST_IDLE;
            end
            ST_RI_WR: begin
                if (mem_fin)
                    state_nxt = ST_RI_WAIT;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Target address of a console access
    wire [ADDR_W-1:0] key_addr = fold((do_dep | do_exam) ? con_s.addr : pc_r);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r     <= ST_IDLE;
            key_q_r     <= '0;
            mem_req_r   <= '0;
            mem_valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            key_q_r <= con_s.key;
            if (do_dep | do_depn) begin
                mem_req_r   <= '{we: 1'b1, addr: key_addr, wdata: con_s.acc};
                mem_valid_r <= 1'b1;
            end else if (do_exam | do_examn) begin
                mem_req_r   <= '{we: 1'b0, addr: key_addr, wdata: '0};
                mem_valid_r <= 1'b1;
            end else if (ri_word) begin
                mem_req_r   <= '{we: 1'b1, addr: ri_addr_r, wdata: rd_buf_r};
                mem_valid_r <= 1'b1;
            end else if (mem_fin) begin
                mem_valid_r <= 1'b0;
            end
        end
    end

    // Central registers as seen on the console
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_r      <= '0;
            ma_r      <= '0;
            ac_r      <= '0;
            mb_r      <= '0;
            ri_addr_r <= '0;
            cpu_run_r <= 1'b0;
        end else begin
            if (mem_fin) begin
                ma_r <= mem_req_r.addr;
                mb_r <= mem_req_r.we ? mem_req_r.wdata : mem_rdata_i;
                ac_r <= mem_req_r.we ? mem_req_r.wdata : mem_rdata_i;
                // Sequential keys continue from here
                pc_r <= fold(mem_req_r.addr + ADDR_W'(1));
            end
            if (do_ri)
                ri_addr_r <= fold(con_s.addr);
            else if (mem_fin & (state_r == ST_RI_WR))
                ri_addr_r <= fold(ri_addr_r + ADDR_W'(1));
            if (do_start) begin
                pc_r      <= fold(con_s.addr);
                cpu_run_r <= 1'b1;
            end else if (do_cont) begin
                cpu_run_r <= 1'b1;
            end
        end
    end

    // Reader control: run, mode, done, assembly buffer
    wire rd_go_sw  = wr_ctrl & pwdata[CTRL_RD_GO];
    wire ri_go     = (state_r == ST_RI_WAIT) & ~rd_done_r & ~rd_run_r &
                     con_s.ready & ~tape_end_i;
    wire rd_take   = rd_run_r & frame_valid_i;
    wire bin_frame = frame_i[BIN_FRAME_BIT];
    // Frames without the binary hole are leader and are skipped
    wire seg_take  = rd_take & rd_mode_r & bin_frame;
    wire seg_last  = seg_cnt_r == CNT_W'(SEG_CNT - 1);
    wire rd_item   = (seg_take & seg_last) | (rd_take & ~rd_mode_r);
    wire rd_clear  = rd_rbuf | (ri_word & ~rd_item);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_run_r  <= 1'b0;
            rd_mode_r <= 1'b0;
            rd_done_r <= 1'b0;
            rd_buf_r  <= '0;
            seg_cnt_r <= '0;
        end else begin
            if (do_ri)
                rd_mode_r <= 1'b1;
            else if (wr_ctrl & idle)
                rd_mode_r <= pwdata[CTRL_RD_BIN];
            if (rd_item | tape_end_i)
                rd_run_r <= 1'b0;
            else if (rd_go_sw | ri_go)
                rd_run_r <= 1'b1;
            if (rd_item)
                rd_done_r <= 1'b1;
            else if (rd_clear)
                rd_done_r <= 1'b0;
            if (rd_go_sw | ri_go) begin
                seg_cnt_r <= '0;
            end else if (seg_take) begin
                rd_buf_r  <= {rd_buf_r[WORD_W-SEG_W-1:0], frame_i[SEG_W-1:0]};
                seg_cnt_r <= seg_last ? '0 : seg_cnt_r + CNT_W'(1);
            end else if (rd_take & ~rd_mode_r) begin
                rd_buf_r  <= WORD_W'(frame_i);
            end
        end
    end

    // Punch buffer and frame out
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pun_buf_r   <= '0;
            pun_mode_r  <= 1'b0;
            pun_frame_r <= '0;
            pun_stb_r   <= 1'b0;
        end else begin
            pun_stb_r <= wr_pbuf;
            if (wr_ctrl)
                pun_mode_r <= pwdata[CTRL_PUN_BIN];
            if (wr_pbuf) begin
                pun_buf_r   <= pwdata[WORD_W-1:0];
                pun_frame_r <= pun_mode_r ? {PUNCH_BIN_TAG, pwdata[SEG_W-1:0]}
                                          : pwdata[FRAME_W-1:0];
            end
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    wire [IRQ_W-1:0] irq_set = {wr_pbuf, ri_end, mem_fin & (state_r != ST_RI_WR), rd_item};
    wire [IRQ_W-1:0] irq_clr = (apb_wr & hit_istat) ? pwdata[IRQ_W-1:0] : '0;
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (apb_wr & hit_imask)
                irq_mask_r <= pwdata[IRQ_W-1:0];
            irq_r <= |(irq_stat_nxt & ((apb_wr & hit_imask) ? pwdata[IRQ_W-1:0] : irq_mask_r));
        end
    end

    // APB slave, answer in the first access cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup & ~hit_any;
            prdata_r  <= (apb_setup & ~pwrite) ? rdata_mux : '0;
        end
    end

    assign prdata                   = prdata_r;
    assign pready                   = pready_r;
    assign pslverr                  = pslverr_r;
    assign irq_o                    = irq_r;
    assign mem_req_o                = mem_req_r;
    assign mem_valid_o              = mem_valid_r;
    assign reader_run_o             = rd_run_r;
    assign reader_binary_o          = rd_mode_r;
    assign reader_done_o            = rd_done_r;
    assign reader_assembly_buffer_o = rd_buf_r;
    assign punch_frame_o            = pun_frame_r;
    assign punch_strobe_o           = pun_stb_r;
    assign cpu_run_o                = cpu_run_r;
    assign program_counter_o        = pc_r;
    assign accumulator_reg_o        = ac_r;
    assign memory_buffer_reg_o      = mb_r;
    assign memory_address_reg_o     = ma_r;
endmodule : cdr_console
`default_nettype wire

// File: verif/cdr_chk.sv
/* Port-level assertions for cdr_console.
   Assumes it is bound to every cdr_console instance on one clock. */
`timescale 1ns/1ps
`default_nettype none
module cdr_chk
    import cdr_pkg::*;
#(
    parameter bit MEM_4K = 1'b0
) (
    input wire logic                  sys_clk_i,
    input wire logic                  rst_i,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire cdr_pkg::cdr_mem_req_t mem_req_o,
    input wire logic                  mem_valid_o,
    input wire logic                  mem_ack_i,
    input wire logic [WORD_W-1:0]     mem_rdata_i,
    input wire logic                  frame_valid_i,
    input wire logic [FRAME_W-1:0]    frame_i,
    input wire logic                  tape_end_i,
    input wire logic                  reader_run_o,
    input wire logic                  reader_binary_o,
    input wire logic                  reader_done_o,
    input wire logic [WORD_W-1:0]     reader_assembly_buffer_o,
    input wire logic                  punch_strobe_o,
    input wire logic [ADDR_W-1:0]     program_counter_o,
    input wire logic [WORD_W-1:0]     accumulator_reg_o,
    input wire logic [ADDR_W-1:0]     memory_address_reg_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_mem_hold: assert property (mem_valid_o && !mem_ack_i |=> mem_valid_o && $stable(mem_req_o))
        else $error("memory request changed before ack");
    a_mem_release: assert property (mem_valid_o && mem_ack_i |=> !mem_valid_o)
        else $error("memory request not released");
    // Read-in writes run in binary mode and are left out
    a_dep_regs: assert property (mem_valid_o && mem_ack_i && mem_req_o.we && !reader_binary_o |=>
        program_counter_o == $past(mem_req_o.addr) + 13'h1 && memory_address_reg_o == $past(mem_req_o.addr)
        && accumulator_reg_o == $past(mem_req_o.wdata))
        else $error("deposit registers wrong");
    a_exam_load: assert property (mem_valid_o && mem_ack_i && !mem_req_o.we |=>
        accumulator_reg_o == $past(mem_rdata_i))
        else $error("examine data not loaded");
    a_done_stops: assert property ($rose(reader_done_o) |-> !reader_run_o)
        else $error("reader still running at done");
    a_bin_shift: assert property (frame_valid_i && reader_run_o && reader_binary_o && frame_i[7] |=>
        reader_assembly_buffer_o == {$past(reader_assembly_buffer_o[11:0]), $past(frame_i[5:0])})
        else $error("binary frame not shifted in");
    a_tape_end: assert property (tape_end_i && reader_run_o |=> !reader_run_o)
        else $error("reader runs past tape end");
    a_punch_pulse: assert property (punch_strobe_o |=> !punch_strobe_o)
        else $error("punch strobe too long");
    a_addr_fold: assert property (mem_valid_o |-> !(MEM_4K && mem_req_o.addr[HI_ADDR_BIT]))
        else $error("high address bit used in 4K");

    c_write: cover property (mem_valid_o && mem_ack_i && mem_req_o.we);
    c_read: cover property (mem_valid_o && mem_ack_i && !mem_req_o.we);
    c_done: cover property ($rose(reader_done_o));
    c_punch: cover property (punch_strobe_o);
endmodule : cdr_chk

bind cdr_console cdr_chk #(.MEM_4K(MEM_4K)) u_chk (.*);
`default_nettype wire

// File: verif/cdr_mem_model.sv
/* Partner core memory: answers one console request after lat_i idle cycles.
   Assumes the request is held until the one-cycle ack. */
`timescale 1ns/1ps
`default_nettype none
module cdr_mem_model
    import cdr_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    input  wire logic [3:0]            lat_i,
    input  wire cdr_pkg::cdr_mem_req_t req_i,
    input  wire logic                  valid_i,
    output logic                       ack_o,
    output logic      [WORD_W-1:0]     rdata_o
);
    logic [WORD_W-1:0] mem [0:8191];
    logic [3:0]        cnt_r;
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            cnt_r <= 4'h0;
            rdata_o <= 18'h0;
        end else if (valid_i && !ack_o && cnt_r >= lat_i) begin
            ack_o <= 1'b1;
            cnt_r <= 4'h0;
            rdata_o <= mem[req_i.addr];
            if (req_i.we) begin
                mem[req_i.addr] <= req_i.wdata;
            end
        end else begin
            ack_o <= 1'b0;
            cnt_r <= (valid_i && !ack_o) ? cnt_r + 4'h1 : 4'h0;
            // Junk outside the ack cycle so stale data is never trusted
            rdata_o <= ~rdata_o;
        end
    end
endmodule : cdr_mem_model
`default_nettype wire

// File: verif/tb_top.sv
/* Self-checking bench for cdr_console: APB, console keys, tape frames.
   Assumes cdr_chk binds itself and cdr_mem_model stands for core memory. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cdr_pkg::*;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0, frame_i = 8'h0, punch_frame_o;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic pready, pslverr, irq_o, re, mem_valid_o, mem_ack_i, punch_strobe_o, cpu_run_o;
    logic frame_valid_i = 1'b0, tape_end_i = 1'b0, reader_ready_i = 1'b0;
    logic reader_run_o, reader_binary_o, reader_done_o;
    logic [KEY_W-1:0] key_pins_i = 7'h0;
    logic [ADDR_W-1:0] addr_switch_i = 13'h0, program_counter_o, memory_address_reg_o;
    logic [WORD_W-1:0] acc_switch_i = 18'h0, mem_rdata_i, reader_assembly_buffer_o;
    logic [WORD_W-1:0] accumulator_reg_o, memory_buffer_reg_o;
    logic [3:0] lat = 4'h0;
    cdr_mem_req_t mem_req_o;
    int error_cnt = 0, samples_checked = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    cdr_console u_dut (.*);
    cdr_mem_model u_mem (.sys_clk_i, .rst_i, .lat_i(lat), .req_i(mem_req_o), .valid_i(mem_valid_o),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        do @(posedge sys_clk_i); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rq, exp);
    endtask : rd

    task automatic wop;
        do @(posedge sys_clk_i); while (mem_valid_o !== 1'b1);
        do @(posedge sys_clk_i); while (mem_valid_o === 1'b1);
    endtask : wop

    // Held through the access, so a short access is not missed
    task automatic key(input int k, input logic op);
        @(posedge sys_clk_i);
        key_pins_i[k] <= 1'b1;
        if (op) wop();
        else repeat (4) @(posedge sys_clk_i);
        key_pins_i[k] <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
    endtask : key

    task automatic frm(input logic [7:0] v);
        @(posedge sys_clk_i);
        frame_valid_i <= 1'b1;
        frame_i <= v;
        @(posedge sys_clk_i);
        frame_valid_i <= 1'b0;
        frame_i <= ~v;
    endtask : frm

    task automatic wrun;
        while (reader_run_o !== 1'b1) @(posedge sys_clk_i);
    endtask : wrun

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        acc_switch_i <= 18'h00400;
        repeat (3) @(posedge sys_clk_i);
        rd("switches", OFF_SWITCH, 32'h400);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped error", {31'h0, re}, 32'h1);
        chk("unmapped data", rq, 32'h0);
        apb(1'b1, OFF_IRQ_MASK, 32'h2);
        addr_switch_i <= 13'h1ff2;
        acc_switch_i <= 18'h2a5c3;
        key(KEY_DEP, 1'b1);
        chk("deposit cell", u_mem.mem[13'h1ff2], 32'h2a5c3);
        chk("deposit pc", program_counter_o, 32'h1ff3);
        chk("deposit mb", memory_buffer_reg_o, 32'h2a5c3);
        chk("deposit ma", memory_address_reg_o, 32'h1ff2);
        chk("deposit ac", accumulator_reg_o, 32'h2a5c3);
        lat <= 4'h3;
        for (int i = 0; i < 2; i++) begin
            acc_switch_i <= 18'h10 + 18'(i);
            key(KEY_DEPN, 1'b1);
            chk("next cell", u_mem.mem[13'h1ff3 + i], 32'h10 + i);
        end
        chk("next pc", program_counter_o, 32'h1ff5);
        key(KEY_EXAM, 1'b1);
        chk("examine mb", memory_buffer_reg_o, 32'h2a5c3);
        addr_switch_i <= 13'h0555;
        key(KEY_EXAMN, 1'b1);
        chk("view next mb", memory_buffer_reg_o, 32'h10);
        chk("view next ma", memory_address_reg_o, 32'h1ff3);
        chk("irq raised", irq_o, 32'h1);
        rd("irq status", OFF_IRQ_STAT, 32'h2);
        apb(1'b1, OFF_IRQ_STAT, 32'hf);
        repeat (2) @(posedge sys_clk_i);
        chk("irq cleared", irq_o, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h2);
        apb(1'b1, OFF_PUN_BUF, 32'h3ff77);
        @(posedge sys_clk_i);
        chk("punch strobe", punch_strobe_o, 32'h1);
        chk("punch binary", punch_frame_o, 32'hb7);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_PUN_BUF, 32'h1a5);
        @(posedge sys_clk_i);
        chk("punch alpha", punch_frame_o, 32'ha5);
        apb(1'b1, OFF_CTRL, 32'h4);
        wrun();
        chk("mode alpha", reader_binary_o, 32'h0);
        frm(8'h41);
        @(posedge sys_clk_i);
        chk("done set", reader_done_o, 32'h1);
        chk("run stopped", reader_run_o, 32'h0);
        rd("reader buffer", OFF_RD_BUF, 32'h41);
        @(posedge sys_clk_i);
        chk("done cleared", reader_done_o, 32'h0);
        apb(1'b1, OFF_IRQ_STAT, 32'hf);
        apb(1'b1, OFF_IRQ_MASK, 32'h4);
        addr_switch_i <= 13'h0100;
        key(KEY_READIN, 1'b0);
        reader_ready_i <= 1'b1;
        for (int w = 0; w < 2; w++) begin
            wrun();
            chk("run reading", reader_run_o, 32'h1);
            frm(8'h00);
            for (int f = 1; f < 4; f++) frm(8'h80 | 8'(w * 8 + f));
            wop();
            chk("loaded word", u_mem.mem[13'h0100 + w], {14'h0, 6'(w * 8 + 1), 6'(w * 8 + 2), 6'(w * 8 + 3)});
        end
        chk("mode binary", reader_binary_o, 32'h1);
        wrun();
        tape_end_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        tape_end_i <= 1'b0;
        rd("status idle", OFF_STATUS, 32'h12);
        chk("tape end irq", irq_o, 32'h1);
        addr_switch_i <= 13'h1ff8;
        key(KEY_START, 1'b0);
        chk("start pc", program_counter_o, 32'h1ff8);
        chk("cpu running", cpu_run_o, 32'h1);
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        chk("reset run", cpu_run_o, 32'h0);
        key(KEY_CONT, 1'b0);
        chk("continue run", cpu_run_o, 32'h1);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
